// *** home_return_map.vh ***
// Register map and field positions of the home-return block
// Functional notes
// R1 - Request flag set at power-up, ready rising, home return start, amplifier power loss.
// R2 - Count-type start on dog: back off to dog-off region, then normal sequence.
// R3 - System places dog so it turns off beyond the home point.
// R4 - Start between dog-off and home: assume before dog, overrun home without stopping.
// R5 - Retry start with dog on, limits off: stroke limit error, no motion.
// R6 - Positioning allowed without home return; power-on position is feed position zero.
// R7 - Home-complete reported as bit 4 of the axis status monitor word.
// R8 - Operator corrects gear ratio by actual over commanded, reduced fraction.
// R9 - Dog-type: slow from home speed to creep at dog on, stop at next home.
`ifndef HOME_RETURN_MAP_VH
`define HOME_RETURN_MAP_VH
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_IRQ_STAT 8'h08
`define A_IRQ_MASK 8'h0c
`define A_HOME_SPD 8'h10
`define A_CREEP_SPD 8'h14
`define A_PULSES 8'h18
`define A_TRAVEL 8'h1c
`define A_POS 8'h20
`define B_START 0
`define B_TYPE 1
`define B_RETRY 2
`define B_DIR 3
`define B_REQ 0
`define B_BUSY 1
`define B_ERR 2
`define B_HOME_DONE 4
`define I_DONE 0
`define I_ERR 1
`define I_REQ 2
`endif

// *** home_return_reference_logic.v ***
// Home-return sequencer, position reference and AXI4-Lite register file
`timescale 1ns/1ps
`default_nettype none
`include "home_return_map.vh"
module home_return_reference_logic #(
	parameter SPW = 16
)(
	input wire mclk,
	input wire rst,
	input wire controller_ready_signal,
	input wire amp_power_ok,
	input wire near_dog,
	input wire upper_limit,
	input wire lower_limit,
	input wire home_mark,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg step_en_r,
	output reg step_dir_r,
	output reg [SPW-1:0] speed_cmd_r,
	output reg irq_r
);
	localparam S_IDLE = 3'd0;
	localparam S_BACK = 3'd1;
	localparam S_FAST = 3'd2;
	localparam S_CREEP = 3'd3;
	localparam S_DONE = 3'd4;
	reg [2:0] st_r;
	reg [3:0] ctrl_r;
	reg [SPW-1:0] home_spd_r;
	reg [SPW-1:0] creep_spd_r;
	reg [31:0] pulses_per_rotation_param;
	reg [31:0] travel_per_rotation_param;
	reg [31:0] pos_r;
	reg req_r;
	reg err_r;
	reg done_r;
	reg [2:0] istat_r;
	reg [2:0] imask_r;
	reg rdy_q_r;
	reg amp_q_r;
	reg por_r;
	reg [7:0] awa_r;
	reg [31:0] wd_r;
	reg [3:0] ws_r;
	reg aw_have_r;
	reg w_have_r;
	wire do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
	wire start_p = do_wr && awa_r == `A_CTRL && ws_r[0] && wd_r[`B_START];
	wire busy = st_r != S_IDLE;
	wire ev_done = st_r == S_DONE;
	wire ev_err = start_p && !busy && ctrl_r[`B_RETRY] && near_dog && !upper_limit && !lower_limit;
	wire ev_req = por_r || (controller_ready_signal && !rdy_q_r) || start_p || (amp_q_r && !amp_power_ok); // [R1]
	wire [31:0] axis_status_monitor = {27'h0, done_r, 1'b0, err_r, busy, req_r}; // [R7]
	wire [2:0] ev = {ev_req, ev_err, ev_done};
	wire [2:0] clr = (do_wr && awa_r == `A_IRQ_STAT && ws_r[0]) ? wd_r[2:0] : 3'h0;
	reg [31:0] rd;
	always @*
	begin
		case (s_axi_araddr)
			`A_CTRL: rd = {28'h0, ctrl_r};
			`A_STATUS: rd = axis_status_monitor;
			`A_IRQ_STAT: rd = {29'h0, istat_r};
			`A_IRQ_MASK: rd = {29'h0, imask_r};
			`A_HOME_SPD: rd = {{(32-SPW){1'b0}}, home_spd_r};
			`A_CREEP_SPD: rd = {{(32-SPW){1'b0}}, creep_spd_r};
			`A_PULSES: rd = pulses_per_rotation_param;
			`A_TRAVEL: rd = travel_per_rotation_param;
			`A_POS: rd = pos_r;
			default: rd = 32'h0;
		endcase
	end
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awa_r <= 8'h0;
			wd_r <= 32'h0;
			ws_r <= 4'h0;
			ctrl_r <= 4'h0;
			home_spd_r <= {SPW{1'b0}};
			creep_spd_r <= {SPW{1'b0}};
			pulses_per_rotation_param <= 32'h1;
			travel_per_rotation_param <= 32'h1;
			imask_r <= 3'h0;
			istat_r <= 3'h0;
			irq_r <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_r <= 1'b1;
				awa_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				// Whole-word writes only; partial strobes leave these registers untouched, though byte 0 still starts a home return and clears interrupt status
				if (ws_r == 4'hf)
				begin
					case (awa_r)
						`A_CTRL: ctrl_r <= {wd_r[3:1], 1'b0};
						`A_IRQ_MASK: imask_r <= wd_r[2:0];
						`A_HOME_SPD: home_spd_r <= wd_r[SPW-1:0];
						`A_CREEP_SPD: creep_spd_r <= wd_r[SPW-1:0];
						`A_PULSES: pulses_per_rotation_param <= wd_r; // [R8]
						`A_TRAVEL: travel_per_rotation_param <= wd_r; // [R8]
						default: ;
					endcase
				end
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd;
			end
			else
			begin
				s_axi_arready <= 1'b0;
				if (s_axi_rvalid && s_axi_rready)
					s_axi_rvalid <= 1'b0;
			end
			// Set wins over a same-cycle write-one clear
			istat_r <= (istat_r & ~clr) | ev;
			irq_r <= |(((istat_r & ~clr) | ev) & imask_r);
		end
	end
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			st_r <= S_IDLE;
			por_r <= 1'b1;
			rdy_q_r <= 1'b0;
			amp_q_r <= 1'b0;
			req_r <= 1'b0;
			err_r <= 1'b0;
			done_r <= 1'b0;
			pos_r <= 32'h0; // [R6]
			step_en_r <= 1'b0;
			step_dir_r <= 1'b0;
			speed_cmd_r <= {SPW{1'b0}};
		end
		else
		begin
			por_r <= 1'b0;
			rdy_q_r <= controller_ready_signal;
			amp_q_r <= amp_power_ok;
			if (ev_req)
				req_r <= 1'b1; // [R1]
			else if (ev_done)
				req_r <= 1'b0;
			if (ev_req)
				done_r <= 1'b0;
			else if (ev_done)
				done_r <= 1'b1; // [R7]
			if (start_p)
				err_r <= ev_err; // [R5]
			if (step_en_r)
				pos_r <= step_dir_r ? pos_r + 32'h1 : pos_r - 32'h1;
			case (st_r)
				S_IDLE:
				begin
					step_en_r <= 1'b0;
					speed_cmd_r <= {SPW{1'b0}};
					if (start_p && !ev_err) // [R5]
					begin
						step_en_r <= 1'b1;
						speed_cmd_r <= home_spd_r;
						// Count type on the dog backs out first [R2]
						if (!ctrl_r[`B_TYPE] && near_dog)
						begin
							st_r <= S_BACK;
							step_dir_r <= !ctrl_r[`B_DIR];
						end
						else
						begin
							// Dog state is the only clue, so a start past dog-off overruns home [R4]
							st_r <= S_FAST;
							step_dir_r <= ctrl_r[`B_DIR];
						end
					end
				end
				S_BACK:
					if (!near_dog) // [R2]
					begin
						st_r <= S_FAST;
						step_dir_r <= ctrl_r[`B_DIR];
					end
				S_FAST:
					if (near_dog) // [R9]
					begin
						st_r <= S_CREEP;
						speed_cmd_r <= creep_spd_r;
					end
				S_CREEP:
					if (home_mark) // [R9]
					begin
						st_r <= S_DONE;
						step_en_r <= 1'b0;
						speed_cmd_r <= {SPW{1'b0}};
						pos_r <= 32'h0;
					end
				S_DONE:
					st_r <= S_IDLE;
				default:
					st_r <= S_IDLE;
			endcase
		end
	end
endmodule // home_return_reference_logic
`default_nettype wire

// *** axis_model.sv ***
// Axis, near-point dog and limit switch model
`timescale 1ns/1ps
`default_nettype none
module axis_model(
	input wire logic mclk,
	input wire logic step_en_r,
	input wire logic step_dir_r,
	output logic near_dog,
	output logic home_mark,
	output logic upper_limit,
	output logic lower_limit
);
	int pos = 100;
	// Dog covers home and ends past it
	assign near_dog = pos >= 5 && pos <= 40;
	assign home_mark = pos == 10;
	assign upper_limit = pos > 900;
	assign lower_limit = pos < -900;
	always @(posedge mclk)
		if (step_en_r)
			pos <= step_dir_r ? pos + 1 : pos - 1;
endmodule // axis_model
`default_nettype wire

// *** hr_props.sv ***
// Port checker of the home-return block
`timescale 1ns/1ps
`default_nettype none
module hr_props #(parameter SPW = 16)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic near_dog,
	input wire logic home_mark,
	input wire logic step_en_r,
	input wire logic [SPW-1:0] speed_cmd_r,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	a_home_stop: assert property (step_en_r && home_mark && near_dog |=> !step_en_r) else $error("no stop");
	a_creep_slow: assert property (step_en_r && $rose(near_dog) |-> ##[1:3] $changed(speed_cmd_r)) else $error("no creep");
	a_move_speed: assert property (step_en_r |-> speed_cmd_r != 0) else $error("zero speed");
	a_idle_speed: assert property (!step_en_r && !$past(step_en_r) |-> speed_cmd_r == 0) else $error("idle speed");
	a_read_ans: assert property (s_axi_arready |-> s_axi_rvalid) else $error("late read");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid held");
	a_write_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0) else $error("bresp");
	a_read_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0) else $error("rresp");
endmodule // hr_props
bind home_return_reference_logic hr_props #(.SPW(SPW)) u_props(.*);
`default_nettype wire

// *** tb_home_return_reference_logic.sv ***
// Testbench of the home-return block
`timescale 1ns/1ps
`default_nettype none
`include "home_return_map.vh"
module tb_home_return_reference_logic;
	logic mclk = 0, rst = 1, controller_ready_signal = 1, amp_power_ok = 1;
	logic near_dog, upper_limit, lower_limit, home_mark, step_en_r, step_dir_r, irq_r;
	logic [15:0] speed_cmd_r;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int n_fail = 0, cmp_count = 0, mv, up, i;
	home_return_reference_logic DUT(.*);
	axis_model mdl(.*);
	initial forever #2 mclk = ~mclk;
	task tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task hang;
		n_fail++;
		tally_and_finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		i = 0;
		// Wait at least one edge so a response still standing from the last call is not taken
		do
		begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 0;
			if (s_axi_wready)
				s_axi_wvalid <= 0;
			i++;
		end
		while (i < 99 && !s_axi_bvalid);
		s_axi_bready <= 0;
		if (!s_axi_bvalid)
			hang;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		i = 0;
		do
		begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 0;
			i++;
		end
		while (i < 99 && !s_axi_rvalid);
		v = s_axi_rdata;
		s_axi_rready <= 0;
		if (!s_axi_rvalid)
			hang;
		@(posedge mclk);
	endtask
	// Config is written before the start bit, which uses latched config
	task run(input logic [31:0] c, input int p);
		mdl.pos = p;
		wr(`A_CTRL, c);
		wr(`A_CTRL, c | 1);
		mv = 0;
		up = 0;
		for (i = 0; i < 999 && !irq_r; i++)
		begin
			@(posedge mclk);
			mv += step_en_r;
			up += step_en_r & step_dir_r;
		end
		if (i == 999)
			hang;
		wr(`A_IRQ_STAT, 3);
		rd(`A_STATUS);
	endtask
	task t_reset;
		rd(`A_STATUS);
		chk("status", 1, v & 32'h17);
		rd(`A_POS);
		chk("pos", 0, v);
		rd(8'h40);
		chk("unmapped", 0, v);
		rd(`A_PULSES);
		chk("pulses reset", 1, v);
		// Reduced gear fraction: numerator to travel, denominator to pulses
		wr(`A_TRAVEL, 32'h07b0fd80);
		wr(`A_PULSES, 32'h0782d7c1);
		rd(`A_TRAVEL);
		chk("travel", 32'h07b0fd80, v);
		rd(`A_PULSES);
		chk("pulses", 32'h0782d7c1, v);
		wr(`A_IRQ_MASK, 4);
		repeat (3) @(posedge mclk);
		chk("irq", 1, irq_r);
		wr(`A_IRQ_STAT, 4);
		repeat (3) @(posedge mclk);
		chk("irq off", 0, irq_r);
		$display("reset test done");
	endtask
	task t_homes;
		wr(`A_IRQ_MASK, 3);
		wr(`A_HOME_SPD, 8);
		wr(`A_CREEP_SPD, 2);
		run(2, 100);
		chk("dog done", 32'h10, v & 32'h17);
		rd(`A_POS);
		chk("home pos", 0, v);
		run(0, 20);
		chk("back off", 1, up > 0);
		chk("count done", 32'h10, v & 32'h17);
		$display("home test done");
	endtask
	task t_events;
		controller_ready_signal <= 0;
		repeat (3) @(posedge mclk);
		controller_ready_signal <= 1;
		repeat (3) @(posedge mclk);
		rd(`A_STATUS);
		chk("ready req", 1, v[0]);
		run(0, 20);
		amp_power_ok <= 0;
		repeat (3) @(posedge mclk);
		amp_power_ok <= 1;
		rd(`A_STATUS);
		chk("power req", 1, v[0]);
		run(4, 20);
		chk("retry moves", 0, mv);
		chk("retry err", 4, v & 4);
		$display("event test done");
	endtask
	// Started off the dog, the axis takes itself to be short of it and never stops at home
	task t_overrun;
		mdl.pos = 3;
		wr(`A_CTRL, 2);
		wr(`A_CTRL, 3);
		repeat (50) @(posedge mclk);
		chk("overrun moving", 1, step_en_r);
		chk("overrun speed", 8, speed_cmd_r);
		chk("overrun no done", 0, irq_r);
		// Only a reset stops the runaway axis
		rst <= 1;
		repeat (4) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		chk("reset stop", 0, step_en_r);
		rd(`A_STATUS);
		chk("reset req", 1, v & 32'h17);
		rd(`A_POS);
		chk("reset pos", 0, v);
		$display("overrun test done");
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		t_reset;
		t_homes;
		t_events;
		t_overrun;
		tally_and_finish;
	end
endmodule // tb_home_return_reference_logic
`default_nettype wire
